// File: src/dar_fifo.sv
`timescale 1ns/1ns
module dar_fifo import dar_pkg::*; #(
  parameter int W = 29,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  dar_stream_if.snk in_s,
  dar_stream_if.src out_s,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } dar_fifo_st_t;
  dar_fifo_st_t st_reg, st_next;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;
  assign in_s.ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (st_reg.cnt != '0);
  assign out_s.data = mem[st_reg.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  assign level = st_reg.cnt;
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wr] <= in_s.data;
    end
  end
endmodule

// File: src/dar_map.svh
`ifndef DAR_MAP_SVH
`define DAR_MAP_SVH
`define DAR_NUM_INPUTS 4
`define DAR_SEL_W 2
`define DAR_CLK_MHZ 250
`define DAR_MAX_SYM_KHZ 12288
`define DAR_MIN_FS_KHZ 32
`define DAR_MAX_FS_KHZ 192
`define DAR_CNT_W 12
`define DAR_FIFO_DEPTH 16
`define DAR_SAMPLE_W 24
`define DAR_AUDIO_W 29
`define DAR_CS_W 4
`define DAR_SYNC_THRESH 8'd4
`define DAR_BLOCK_FRAMES 8'd192
// Cycles per half-bit at slowest rate: 250 MHz / (32 kHz * 128), rounded down, plus one
`define DAR_MAX_HALF 12'(`DAR_CLK_MHZ * 1000 / (`DAR_MIN_FS_KHZ * 128) + 1)
// Least half-bit: 250 MHz / 12.288 MHz, rounded down, giving 20
`define DAR_MIN_HALF 12'(`DAR_CLK_MHZ * 1000 / `DAR_MAX_SYM_KHZ)
// Frame field positions
`define DAR_BIT_PARITY 31
`define DAR_BIT_CHSTAT 30
`define DAR_BIT_USER 29
`define DAR_BIT_VALID 28
`endif

// File: src/dar_pkg.sv
package dar_pkg;
  typedef enum logic [3:0] {
    DAR_ST_IDLE = 4'b0001,
    DAR_ST_MEAS = 4'b0010,
    DAR_ST_SYNC = 4'b0100,
    DAR_ST_RUN = 4'b1000
  } dar_state_t;
  typedef enum logic [1:0] {
    DAR_PRE_NONE = 2'h0,
    DAR_PRE_BLOCK = 2'h1,
    DAR_PRE_CH_A = 2'h2,
    DAR_PRE_CH_B = 2'h3
  } dar_pre_t;
endpackage

// File: src/dar_receiver.sv
`timescale 1ns/1ns
`include "dar_map.svh"
module dar_receiver import dar_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [`DAR_SEL_W-1:0] input_sel,
  input wire logic [`DAR_NUM_INPUTS-1:0] line_in,
  output logic audio_dma_req,
  input wire logic audio_dma_ack,
  output logic [`DAR_AUDIO_W-1:0] audio_data,
  output logic cs_dma_req,
  input wire logic cs_dma_ack,
  output logic [`DAR_CS_W-1:0] cs_data,
  output logic locked,
  output logic parity_err,
  output logic block_start,
  output logic overrun,
  output logic irq,
  output logic frame_sync
);
  typedef struct packed {
    dar_state_t state;
    logic [2:0] smp;
    logic [`DAR_CNT_W-1:0] run;
    logic [`DAR_CNT_W-1:0] half;
    logic [7:0] nsync;
    logic [7:0] pre_bits;
    logic [3:0] pre_cnt;
    logic [5:0] bitn;
    logic second;
    logic [31:0] shift;
    logic par;
    dar_pre_t pre;
    logic [7:0] frame;
    logic sync;
    logic perr;
    logic blk;
    logic ovr;
    logic [`DAR_AUDIO_W-1:0] adata;
    logic avalid;
    logic [`DAR_CS_W-1:0] cdata;
    logic cvalid;
  } dar_st_t;
  dar_st_t st_reg, st_next;
  logic edge_seen, long_pulse, short_pulse, pre_pulse;
  logic [`DAR_CNT_W-1:0] three_half;
  dar_stream_if #(.W(`DAR_AUDIO_W)) a_in ();
  dar_stream_if #(.W(`DAR_AUDIO_W)) a_out ();
  dar_fifo #(.W(`DAR_AUDIO_W), .DEPTH(`DAR_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_s(a_in),
    .out_s(a_out),
    .level()
  );
  assign a_in.valid = st_reg.avalid;
  assign a_in.data = st_reg.adata;
  assign a_out.ready = audio_dma_ack;
  assign audio_dma_req = a_out.valid;
  assign audio_data = a_out.data;
  assign cs_dma_req = st_reg.cvalid;
  assign cs_data = st_reg.cdata;
  assign locked = (st_reg.state == DAR_ST_RUN);
  assign parity_err = st_reg.perr;
  assign block_start = st_reg.blk;
  assign overrun = st_reg.ovr;
  assign irq = st_reg.perr | st_reg.ovr | st_reg.blk;
  assign frame_sync = st_reg.sync;
  assign edge_seen = st_reg.smp[2] ^ st_reg.smp[1];
  assign three_half = st_reg.half + st_reg.half + st_reg.half;
  assign short_pulse = st_reg.run < st_reg.half + (st_reg.half >> 1);
  assign long_pulse = !short_pulse && (st_reg.run < st_reg.half + st_reg.half + (st_reg.half >> 1));
  assign pre_pulse = st_reg.run >= st_reg.half + st_reg.half + (st_reg.half >> 1);
  always_comb begin
    st_next = st_reg;
    st_next.avalid = 1'b0;
    st_next.blk = 1'b0;
    if (st_reg.cvalid && cs_dma_ack) begin
      st_next.cvalid = 1'b0;
    end
    if (st_reg.avalid && !a_in.ready) begin
      st_next.ovr = 1'b1;
    end
    st_next.smp = {st_reg.smp[1:0], line_in[input_sel]};
    if (st_reg.run != {`DAR_CNT_W{1'b1}}) begin
      st_next.run = st_reg.run + 1'b1;
    end
    if (edge_seen) begin
      st_next.run = `DAR_CNT_W'(1);
    end
    case (st_reg.state)
      DAR_ST_IDLE: begin
        st_next.half = {`DAR_CNT_W{1'b1}};
        st_next.nsync = '0;
        if (enable && edge_seen) begin
          st_next.state = DAR_ST_MEAS;
        end
      end
      DAR_ST_MEAS: begin
        if (edge_seen) begin
          if (st_reg.run < st_reg.half && st_reg.run >= `DAR_MIN_HALF) begin
            st_next.half = st_reg.run;
          end
          st_next.nsync = st_reg.nsync + 1'b1;
          if (st_reg.nsync == 8'hff) begin
            st_next.state = DAR_ST_SYNC;
          end
        end
        if (st_reg.run > `DAR_MAX_HALF * 4) begin
          st_next.state = DAR_ST_IDLE;
        end
      end
      default: begin
        if (!enable || st_reg.run > three_half + st_reg.half) begin
          st_next.state = DAR_ST_IDLE;
        end else if (edge_seen) begin
          if (st_reg.pre_cnt != 4'h0) begin
            st_next.pre_bits = {st_reg.pre_bits[6:0], !short_pulse};
            st_next.pre_cnt = st_reg.pre_cnt + 1'b1;
            if (st_reg.pre_cnt == 4'h3) begin
              st_next.pre_cnt = 4'h0;
              st_next.bitn = 6'h04;
              st_next.second = 1'b0;
              st_next.par = 1'b0;
              st_next.shift = '0;
              // After the lead pulse: short short long is block, long short long is B
              if ({st_reg.pre_bits[1:0], !short_pulse} == 3'b001) begin
                st_next.pre = DAR_PRE_BLOCK;
              end else if ({st_reg.pre_bits[1:0], !short_pulse} == 3'b101) begin
                st_next.pre = DAR_PRE_CH_B;
              end else begin
                st_next.pre = DAR_PRE_CH_A;
              end
              if (st_reg.state == DAR_ST_SYNC) begin
                st_next.nsync = st_reg.nsync + 1'b1;
                if (st_reg.nsync >= `DAR_SYNC_THRESH) begin
                  st_next.state = DAR_ST_RUN;
                end
              end
            end
          end else if (pre_pulse) begin
            st_next.pre_bits = 8'h01;
            st_next.pre_cnt = 4'h1;
          end else if (st_reg.pre != DAR_PRE_NONE) begin
            if (long_pulse) begin
              st_next.shift = {1'b0, st_reg.shift[31:1]};
              st_next.bitn = st_reg.bitn + 1'b1;
              st_next.second = 1'b0;
            end else if (st_reg.second) begin
              st_next.shift = {1'b1, st_reg.shift[31:1]};
              st_next.par = ~st_reg.par;
              st_next.bitn = st_reg.bitn + 1'b1;
              st_next.second = 1'b0;
            end else begin
              st_next.second = 1'b1;
            end
          end
        end
        if (st_reg.bitn == 6'd32 && st_reg.pre != DAR_PRE_NONE) begin
          st_next.pre = DAR_PRE_NONE;
          st_next.bitn = '0;
          if (st_reg.state == DAR_ST_RUN) begin
            st_next.sync = ~st_reg.sync;
            st_next.perr = st_reg.par;
            // samples kept raw for both stream kinds
            st_next.adata = {st_reg.pre == DAR_PRE_CH_B, 3'h0,
                             st_reg.shift[`DAR_BIT_VALID:4]};
            st_next.avalid = 1'b1;
            if (st_reg.pre == DAR_PRE_BLOCK) begin
              st_next.frame = '0;
              st_next.blk = 1'b1;
            end else if (st_reg.pre == DAR_PRE_CH_B) begin
              st_next.frame = st_reg.frame + 1'b1;
            end
            st_next.cdata = {st_reg.pre == DAR_PRE_BLOCK, st_reg.pre == DAR_PRE_CH_B,
                             st_reg.shift[`DAR_BIT_CHSTAT], st_reg.shift[`DAR_BIT_USER]};
            st_next.cvalid = 1'b1;
          end
        end
      end
    endcase
    if (st_next.state == DAR_ST_IDLE) begin
      st_next.pre = DAR_PRE_NONE;
      st_next.pre_cnt = '0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= DAR_ST_IDLE;
      st_reg.pre <= DAR_PRE_NONE;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// File: src/dar_stream_if.sv
`timescale 1ns/1ns
interface dar_stream_if #(parameter int W = 29);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: tb/dar_receiver_assertions.sv
`timescale 1ns/1ns
module dar_receiver_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic audio_dma_req,
  input wire logic audio_dma_ack,
  input wire logic [28:0] audio_data,
  input wire logic cs_dma_req,
  input wire logic cs_dma_ack,
  input wire logic locked,
  input wire logic parity_err,
  input wire logic block_start,
  input wire logic overrun,
  input wire logic irq,
  input wire logic frame_sync
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  rst_quiet_a: assert property (disable iff (1'b0)
    rst |=> !(locked | irq | overrun | audio_dma_req | cs_dma_req))
    else $error("outputs active after reset");
  irq_cause_a: assert property ((parity_err | overrun | block_start) |-> ##[0:1] irq)
    else $error("status flag without interrupt");
  overrun_held_a: assert property (overrun |=> overrun)
    else $error("overrun cleared without reset");
  block_pulse_a: assert property (block_start |=> !block_start)
    else $error("block start longer than one cycle");
  block_lock_a: assert property (block_start |-> locked)
    else $error("block start while not locked");
  sync_lock_a: assert property ($changed(frame_sync) |-> locked)
    else $error("frame sync toggled while not locked");
  sync_space_a: assert property ($changed(frame_sync) |=> $stable(frame_sync) [*8])
    else $error("frame sync toggled too fast");
  cs_clear_a: assert property (cs_dma_req && cs_dma_ack |=> !cs_dma_req)
    else $error("control request not cleared by ack");
  head_hold_a: assert property (audio_dma_req && !audio_dma_ack |=>
    audio_dma_req && $stable(audio_data))
    else $error("audio head lost without ack");
endmodule
bind dar_receiver dar_receiver_checker i_dar_receiver_checker (.clock, .rst, .audio_dma_req,
  .audio_dma_ack, .audio_data, .cs_dma_req, .cs_dma_ack, .locked, .parity_err, .block_start,
  .overrun, .irq, .frame_sync);

// File: tb/dar_src_model.sv
`timescale 1ns/1ns
module dar_src_model #(
  parameter int HALF = 24
) (
  input wire logic clock,
  input wire logic blk_req,
  input wire logic bad_par,
  output logic line
);
  int n = 0;
  logic pend = 1'b0;
  logic inv;
  logic [7:0] pre;
  logic [31:0] sf;
  task automatic half(input logic v);
    line = v;
    repeat (HALF) @(negedge clock);
  endtask
  always @(posedge blk_req) pend = 1'b1;
  initial begin
    line = 1'b0;
    forever begin
      sf = {1'b0, n[2], n[1], 1'b0, ~n[11:0], n[11:0], 4'h0};
      sf[31] = ^sf[30:4] ^ bad_par;
      pre = n[0] ? 8'he4 : (pend ? 8'he8 : 8'he2);
      if (!n[0]) pend = 1'b0;
      inv = line;
      for (int i = 7; i >= 0; i--) half(pre[i] ^ inv);
      for (int i = 4; i < 32; i++) begin
        half(~line);
        half(line ^ sf[i]);
      end
      n++;
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int HALF = 24;
  localparam int SUB = 64 * HALF;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b0;
  logic [1:0] input_sel = 2'h2;
  logic audio_dma_ack = 1'b0;
  logic cs_dma_ack = 1'b0;
  logic noise = 1'b0;
  logic blk_req = 1'b0;
  logic bad_par = 1'b0;
  logic src_line, audio_dma_req, cs_dma_req, locked, parity_err, block_start, overrun, irq;
  logic frame_sync;
  logic [28:0] audio_data;
  logic [3:0] cs_data;
  wire [3:0] line_in;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign line_in = {noise, src_line, ~noise, noise};
  always #2 clock = ~clock;
  always @(negedge clock) noise <= ~noise;
  dar_src_model #(.HALF(HALF)) i_dar_src_model (.clock, .blk_req, .bad_par, .line(src_line));
  dar_receiver i_dar_receiver (.clock, .rst, .enable, .input_sel, .line_in, .audio_dma_req,
    .audio_dma_ack, .audio_data, .cs_dma_req, .cs_dma_ack, .cs_data, .locked, .parity_err,
    .block_start, .overrun, .irq, .frame_sync);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic pop(output logic [28:0] w);
    @(negedge clock);
    for (int k = 0; k < 2 * SUB && audio_dma_req !== 1'b1; k++) @(negedge clock);
    w = audio_data;
    audio_dma_ack = 1'b1;
    @(negedge clock);
    audio_dma_ack = 1'b0;
  endtask
  task automatic drain(output int c);
    logic [28:0] w;
    c = 0;
    while (audio_dma_req === 1'b1 && c < 64) begin
      pop(w);
      c++;
    end
  endtask
  task automatic t_audio();
    logic [28:0] w;
    logic [11:0] nx;
    pop(w);
    nx = w[11:0];
    repeat (6) begin
      pop(w);
      nx = nx + 12'h001;
      check(w[11:0], nx);
      check(w[23:12] ^ w[11:0], 32'hfff);
      check(w[28], w[0]);
    end
    $display("test audio done");
  endtask
  task automatic t_fsync();
    int t = 0;
    int c;
    logic p;
    p = frame_sync;
    repeat (8 * SUB) begin
      @(negedge clock);
      if (frame_sync !== p) t++;
      p = frame_sync;
    end
    check(t, 8);
    drain(c);
    $display("test sync done");
  endtask
  task automatic t_parity();
    bad_par = 1'b1;
    for (int k = 0; k < 3 * SUB && parity_err !== 1'b1; k++) @(negedge clock);
    check(parity_err, 1);
    @(negedge clock);
    check(irq, 1);
    bad_par = 1'b0;
    repeat (3 * SUB) @(negedge clock);
    check(parity_err, 0);
    $display("test parity done");
  endtask
  task automatic t_block();
    blk_req = 1'b1;
    @(negedge clock);
    blk_req = 1'b0;
    for (int k = 0; k < 4 * SUB && block_start !== 1'b1; k++) @(negedge clock);
    check(block_start, 1);
    for (int k = 0; k < 2 * SUB && cs_dma_req !== 1'b1; k++) @(negedge clock);
    check(cs_dma_req, 1);
    check(cs_data[3:2], 2'b10);
    cs_dma_ack = 1'b1;
    @(negedge clock);
    cs_dma_ack = 1'b0;
    check(cs_dma_req, 0);
    $display("test block done");
  endtask
  task automatic t_overrun();
    int c;
    drain(c);
    repeat (18 * SUB) @(negedge clock);
    check(overrun, 1);
    check(irq, 1);
    drain(c);
    check(c, 16);
    check(overrun, 1);
    $display("test overrun done");
  endtask
  task automatic t_idle();
    int c;
    logic p;
    enable = 1'b0;
    repeat (2) @(negedge clock);
    drain(c);
    p = frame_sync;
    repeat (SUB) @(negedge clock);
    check(locked, 0);
    check(audio_dma_req, 0);
    check(frame_sync, p);
    $display("test idle done");
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check({locked, irq, overrun, audio_dma_req, cs_dma_req, parity_err}, 0);
    enable = 1'b1;
    for (int k = 0; k < 40000 && locked !== 1'b1; k++) @(negedge clock);
    check(locked, 1);
    $display("test lock done");
    t_audio();
    t_fsync();
    t_parity();
    t_block();
    t_overrun();
    t_idle();
    end_of_test();
  end
endmodule
